// File: bench/usb_host_rx_ep_props.sv
// Concurrent checks on the ports of the host receive endpoint block.
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_ep_map.vh"
module usb_host_rx_ep_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic stall_seen,
  input wire logic pkt_done,
  input wire logic no_data_try,
  input wire logic nak_halt,
  input wire logic toggle_flip,
  input wire logic in_request,
  input wire logic flush_pulse,
  input wire logic toggle_value,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Register and link relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A write aimed at the control and status word.
  wire logic ctl_wr = wr && addr == `RXEP_CTRL_ADDR;
  ctl_read_zero_a: assert property (rd && addr == `RXEP_CTRL_ADDR |=> rdata[15:10] == 6'h00
    && !rdata[8] && !rdata[7] && !rdata[4]) else $error("write-only control bits read back");
  ep0_tally_hi_a: assert property (rd && addr == `RXEP_EP0_TALLY_ADDR |=> rdata[15:7] == 9'h000)
    else $error("ep0 tally upper bits set");
  rx_tally_hi_a: assert property (rd && addr == `RXEP_IN_TALLY_ADDR |=> rdata[15:13] == 3'h0)
    else $error("rx tally upper bits set");
  req_set_a: assert property (ctl_wr && wdata[5] |=> in_request)
    else $error("request not raised");
  req_clear_a: assert property (pkt_done && in_request && !ctl_wr |=> !in_request)
    else $error("request not dropped on packet");
  tog_clear_a: assert property (ctl_wr && wdata[7] |=> !toggle_value)
    else $error("toggle not cleared");
  tog_write_a: assert property (ctl_wr && !wdata[7] && wdata[10] |=> toggle_value == $past(wdata[9]))
    else $error("toggle not written");
  tog_hold_a: assert property (!toggle_flip && !(ctl_wr && (wdata[7] || wdata[10]))
    |=> $stable(toggle_value)) else $error("toggle changed without cause");
  flush_cause_a: assert property (flush_pulse |-> $past(ctl_wr && wdata[4])
    || $past(ctl_wr && wdata[4], 2)) else $error("flush pulse without flush write");
  // Events reach irq at the edge that takes them; a mask write shows one edge later.
  irq_cause_a: assert property ($rose(irq) |-> $past(stall_seen || pkt_done
    || no_data_try || nak_halt) || $past(wr, 2)) else $error("interrupt rose without cause");
  pkt_irq_a: assert property (pkt_done ##1 !wr |=> irq)
    else $error("no interrupt after packet");
  cover property (stall_seen ##1 !in_request);
  cover property (flush_pulse);
  cover property (ctl_wr && wdata[10]);
endmodule
bind usb_host_rx_ep usb_host_rx_ep_props props (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
  .stall_seen, .pkt_done, .no_data_try, .nak_halt, .toggle_flip, .in_request, .flush_pulse,
  .toggle_value, .irq);
`default_nettype wire

// File: bench/usb_host_rx_ep_tb.sv
// Self-checking bench for the host receive endpoint block.
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_ep_map.vh"
module usb_host_rx_ep_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rx_byte_read = 0, ep0_load = 0, ep0_byte_read = 0;
  logic ep0_empty = 0, crc = 0, stall_seen, pkt_done, pkt_crc_err, no_data_try, nak_halt;
  logic toggle_flip, in_request, flush_pulse, toggle_value, irq;
  logic [2:0] addr = 0;
  logic [15:0] wdata = 0, rdata;
  logic [12:0] pkt_len, len = 0;
  logic [6:0] ep0_load_len = 0;
  logic [1:0] reply = 0;
  int mismatches = 0, compares = 0, flushes = 0;
  localparam logic [2:0] ctl = `RXEP_CTRL_ADDR;
  localparam logic [2:0] sta = `RXEP_IRQ_STAT_ADDR;
  usb_host_rx_ep DUT (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .stall_seen, .pkt_done,
    .pkt_len, .pkt_crc_err, .no_data_try, .nak_halt, .rx_byte_read, .ep0_load, .ep0_load_len,
    .ep0_byte_read, .ep0_empty, .toggle_flip, .in_request, .flush_pulse, .toggle_value, .irq);
  usb_target_model target (.clk, .rst, .in_request, .reply, .len, .crc, .stall_seen,
    .pkt_done, .pkt_len, .pkt_crc_err, .no_data_try, .nak_halt, .toggle_flip);
  // ----------------------------------------------------------------
  // Clock, watchdog and bus tasks
  // ----------------------------------------------------------------
  initial forever #20 clk = ~clk;
  // A hang counts as a mismatch and ends the run.
  initial begin
    #200000;
    mismatches++;
    print_verdict;
  end
  // Each discarded packet shows as one pulse.
  always @(posedge clk) if (flush_pulse === 1'b1) flushes <= flushes + 1;
  task print_verdict;
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  endtask
  task rd_reg(input logic [2:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    d = rdata;
  endtask
  task expect_reg(input logic [2:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd_reg(a, d);
    check(d, e);
  endtask
  task expect_irq(input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({15'h0, irq}, {15'h0, e});
    @(posedge clk);
  endtask
  // Sets the target's answer, writes the control word, then polls for a flag.
  task ask(input logic [1:0] r, input logic [15:0] w, input logic [15:0] m);
    logic [15:0] d;
    reply <= r;
    wr_reg(ctl, w);
    d = 16'h0000;
    for (int i = 0; i < 40 && (d & m) == 16'h0000; i++) rd_reg(ctl, d);
    check(d & m, m);
  endtask
  // Main sequence of scenarios.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    expect_reg(ctl, 16'h0000);
    expect_reg(`RXEP_IRQ_MASK_ADDR, {12'h000, `IRQ_MASK_RESET});
    expect_reg(`RXEP_MODE_ADDR, {14'h0, `MODE_RESET});
    expect_reg(3'h6, 16'h0000);
    expect_reg(`RXEP_IN_TALLY_ADDR, 16'h0000);
    wr_reg(ctl, 16'h0200);
    expect_reg(ctl, 16'h0000);
    wr_reg(ctl, 16'h0600);
    expect_reg(ctl, 16'h0200);
    wr_reg(ctl, 16'h0680);
    expect_reg(ctl, 16'h0000);
    len <= 13'h0005;
    ask(2'h0, 16'h0020, 16'h0001);
    check({15'h0, in_request}, 16'h0000);
    expect_reg(ctl, 16'h0201);
    expect_reg(`RXEP_IN_TALLY_ADDR, 16'h0005);
    expect_reg(sta, 16'h0002);
    expect_irq(1'b1);
    rx_byte_read <= 1;
    @(posedge clk);
    rx_byte_read <= 0;
    expect_reg(`RXEP_IN_TALLY_ADDR, 16'h0004);
    len <= 13'h1FFF;
    crc <= 1;
    ask(2'h0, 16'h0021, 16'h0002);
    expect_reg(ctl, 16'h0003);
    wr_reg(ctl, 16'h0011);
    expect_reg(ctl, 16'h0001);
    expect_reg(`RXEP_IN_TALLY_ADDR, 16'h1FFF);
    wr_reg(ctl, 16'h0011);
    expect_reg(ctl, 16'h0000);
    wr_reg(ctl, 16'h0010);
    check(16'(flushes), 16'h0002);
    wr_reg(sta, 16'h000F);
    expect_irq(1'b0);
    wr_reg(`RXEP_MODE_ADDR, {14'h0, `MODE_ISO});
    len <= 13'h0003;
    ask(2'h0, 16'h0020, 16'h0001);
    expect_reg(ctl, 16'h0209);
    wr_reg(ctl, 16'h0000);
    expect_reg(ctl, 16'h0200);
    ep0_load_len <= 7'h7F;
    ep0_load <= 1;
    @(posedge clk);
    ep0_load <= 0;
    ep0_byte_read <= 1;
    @(posedge clk);
    ep0_byte_read <= 0;
    expect_reg(`RXEP_EP0_TALLY_ADDR, 16'h007E);
    ep0_empty <= 1;
    @(posedge clk);
    ep0_empty <= 0;
    expect_reg(`RXEP_EP0_TALLY_ADDR, 16'h0000);
    wr_reg(`RXEP_MODE_ADDR, {14'h0, `MODE_INTR});
    ask(2'h2, 16'h0020, 16'h0004);
    expect_reg(sta, 16'h0006);
    wr_reg(`RXEP_MODE_ADDR, {14'h0, `MODE_ISO});
    expect_reg(ctl, 16'h0200);
    wr_reg(sta, 16'h000F);
    wr_reg(`RXEP_MODE_ADDR, {14'h0, `MODE_CONTROL});
    wr_reg(`RXEP_IRQ_MASK_ADDR, 16'h000E);
    ask(2'h1, 16'h0020, 16'h0040);
    expect_reg(sta, 16'h0001);
    expect_irq(1'b0);
    wr_reg(`RXEP_IRQ_MASK_ADDR, 16'h000F);
    expect_irq(1'b1);
    wr_reg(ctl, 16'h0000);
    expect_reg(ctl, 16'h0200);
    wr_reg(sta, 16'h000F);
    wr_reg(`RXEP_MODE_ADDR, {14'h0, `MODE_BULK});
    ask(2'h3, 16'h0020, 16'h0008);
    wr_reg(ctl, 16'h0008);
    expect_reg(ctl, 16'h0208);
    expect_reg(sta, 16'h0008);
    wr_reg(ctl, 16'h0000);
    expect_reg(ctl, 16'h0200);
    print_verdict;
  end
endmodule
`default_nettype wire

// File: bench/usb_target_model.sv
// Behavioural USB target that answers the host endpoint's IN requests.
`timescale 1ns/1ps
`default_nettype none
module usb_target_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_request,
  input wire logic [1:0] reply,
  input wire logic [12:0] len,
  input wire logic crc,
  output logic stall_seen,
  output logic pkt_done,
  output logic [12:0] pkt_len,
  output logic pkt_crc_err,
  output logic no_data_try,
  output logic nak_halt,
  output logic toggle_flip
);
  logic [2:0] wait_cnt;
  // One answer every five cycles while a request is pending; idle lines wander.
  always_ff @(posedge clk) begin
    stall_seen <= 1'b0;
    pkt_done <= 1'b0;
    no_data_try <= 1'b0;
    nak_halt <= 1'b0;
    toggle_flip <= 1'b0;
    pkt_len <= ~pkt_len;
    pkt_crc_err <= ~pkt_crc_err;
    if (rst) begin
      pkt_len <= 13'h0000;
      pkt_crc_err <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (!in_request) begin
      wait_cnt <= 3'h0;
    end else if (wait_cnt != 3'h4) begin
      wait_cnt <= wait_cnt + 3'h1;
    end else begin
      wait_cnt <= 3'h0;
      case (reply)
        2'h0: begin
          pkt_done <= 1'b1;
          toggle_flip <= 1'b1;
          pkt_len <= len;
          pkt_crc_err <= crc;
        end
        2'h1: stall_seen <= 1'b1;
        2'h2: no_data_try <= 1'b1;
        default: nak_halt <= 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: inc/usb_rx_ep_map.vh
// Register map, field positions and constants of the host receive endpoint block.
`ifndef USB_RX_EP_MAP_VH
`define USB_RX_EP_MAP_VH

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define RXEP_ADDR_W 3
`define RXEP_CTRL_ADDR 3'h0
`define RXEP_EP0_TALLY_ADDR 3'h1
`define RXEP_IN_TALLY_ADDR 3'h2
`define RXEP_IRQ_STAT_ADDR 3'h3
`define RXEP_IRQ_MASK_ADDR 3'h4
`define RXEP_MODE_ADDR 3'h5

// ----------------------------------------------------------------
// Control and status register fields
// ----------------------------------------------------------------
`define RXEP_DATA_W 16
`define B_TOG_WREN 10
`define B_TOGGLE 9
`define B_TOG_CLR 7
`define B_STALL 6
`define B_REQ 5
`define B_FLUSH 4
`define B_CRC_NAK 3
`define B_NORESP 2
`define B_FULL 1
`define B_READY 0

// ----------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------
`define IRQ_W 4
`define IRQ_STALL 0
`define IRQ_READY 1
`define IRQ_NORESP 2
`define IRQ_NAK 3
`define IRQ_MASK_RESET 4'hF

// ----------------------------------------------------------------
// Transfer type encodings and other constants
// ----------------------------------------------------------------
`define MODE_W 2
`define MODE_CONTROL 2'h0
`define MODE_ISO 2'h1
`define MODE_BULK 2'h2
`define MODE_INTR 2'h3
`define MODE_RESET 2'h2
`define STRIKE_W 2
`define STRIKE_LIMIT 2'h3

`endif

// File: logic/usb_host_rx_ep.v
// Host receive endpoint control, status, byte tallies and interrupt logic.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_ep_map.vh"

// Behaviour
// - Toggle bit 9 reads current data toggle; writes apply only with write enable.
// - Toggle write enable bit 10 clears itself after the toggle is written.
// - Writing one to bit 7 forces the data toggle to zero.
// - A received STALL sets bit 6 and raises an interrupt; software clears it.
// - Writing one to bit 5 requests an IN transaction; packet arrival clears it.
// - Writing one to bit 4 discards the head packet; packet ready clears unless another packet waits.
// - Flush does nothing without packet ready; double buffering may need two flushes.
// - Isochronous: bit 3 shows head packet CRC error while packet ready is set.
// - Bulk: bit 3 sets when NAK limit halts the endpoint; software clears it.
// - Three attempts without data set bit 2 and raise an interrupt.
// - No-response flag reads zero for isochronous endpoints.
// - Bit 1 is set while the receive FIFO holds no room for packets.
// - Packet arrival sets bit 0 and interrupts; software clears it after unloading.
// - Endpoint zero tally bits 6-0 report bytes held in that FIFO.
// - Receive tally bits 12-0 report bytes left in the head packet.
module usb_host_rx_ep #(
  parameter SLOTS = 2,
  parameter PTR_W = 1,
  parameter LEN_W = 13,
  parameter EP0_W = 7
) (
  input wire clk,
  input wire rst,
  input wire [`RXEP_ADDR_W-1:0] addr,
  input wire [`RXEP_DATA_W-1:0] wdata,
  input wire wr,
  input wire rd,
  output reg [`RXEP_DATA_W-1:0] rdata,
  input wire stall_seen,
  input wire pkt_done,
  input wire [LEN_W-1:0] pkt_len,
  input wire pkt_crc_err,
  input wire no_data_try,
  input wire nak_halt,
  input wire rx_byte_read,
  input wire ep0_load,
  input wire [EP0_W-1:0] ep0_load_len,
  input wire ep0_byte_read,
  input wire ep0_empty,
  input wire toggle_flip,
  output reg in_request,
  output reg flush_pulse,
  output reg toggle_value,
  output reg irq
);

  // ----------------------------------------------------------------
  // Constants derived from the parameters
  // ----------------------------------------------------------------
  localparam [PTR_W-1:0] PTR_ONE = 1;
  localparam [PTR_W:0] CNT_ONE = 1;
  localparam [PTR_W:0] CNT_FULL = SLOTS[PTR_W:0];
  localparam [LEN_W-1:0] LEN_ONE = 1;
  localparam [EP0_W-1:0] EP0_ONE = 1;
  localparam [EP0_W-1:0] EP0_ZERO = 0;
  localparam [`STRIKE_W-1:0] STRIKE_ONE = 1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [LEN_W-1:0] len_q [0:SLOTS-1];
  reg err_q [0:SLOTS-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0] pkt_count;
  reg packet_ready_flag;
  reg head_crc_err;
  reg [LEN_W-1:0] in_packet_byte_total;
  reg [EP0_W-1:0] ep_zero_byte_total;
  reg stall_received_flag;
  reg noresp_flag;
  reg nak_timeout_flag;
  reg fifo_full_flag;
  reg toggle_write_enable;
  reg [`STRIKE_W-1:0] strikes;
  reg [`IRQ_W-1:0] irq_status;
  reg [`IRQ_W-1:0] irq_mask;
  reg [`MODE_W-1:0] ep_mode;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  reg ctrl_wr;
  reg is_iso;
  reg push;
  reg pop;
  reg flush_hit;
  reg strike_hit;
  reg [PTR_W-1:0] next_wr_ptr;
  reg [PTR_W-1:0] next_rd_ptr;
  reg [PTR_W:0] next_pkt_count;
  reg next_packet_ready;
  reg next_head_err;
  reg [LEN_W-1:0] next_in_total;
  reg [EP0_W-1:0] next_ep0_total;
  reg next_stall;
  reg next_noresp;
  reg next_nak;
  reg next_request;
  reg next_toggle;
  reg next_twe;
  reg [`STRIKE_W-1:0] next_strikes;
  reg [`IRQ_W-1:0] irq_set;
  reg [`IRQ_W-1:0] next_irq_status;

  // Decodes the accesses and works out every next value except mask, mode, full flag and irq.
  always @* begin
    ctrl_wr = wr && (addr == `RXEP_CTRL_ADDR);
    is_iso = (ep_mode == `MODE_ISO);
    push = pkt_done && (pkt_count != CNT_FULL);
    flush_hit = ctrl_wr && wdata[`B_FLUSH] && packet_ready_flag;
    pop = flush_hit || (ctrl_wr && packet_ready_flag && !wdata[`B_READY]);
    next_wr_ptr = push ? wr_ptr + PTR_ONE : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + PTR_ONE : rd_ptr;
    next_pkt_count = pkt_count;
    if (push && !pop) begin
      next_pkt_count = pkt_count + CNT_ONE;
    end else if (pop && !push) begin
      next_pkt_count = pkt_count - CNT_ONE;
    end
    // A popped packet reveals the next one, hence two flushes for two buffers.
    next_packet_ready = push || (pop ? (pkt_count > CNT_ONE) : packet_ready_flag);
    next_in_total = in_packet_byte_total;
    next_head_err = head_crc_err;
    if (push && (pkt_count == {(PTR_W+1){1'b0}} || (pop && pkt_count == CNT_ONE))) begin
      next_in_total = pkt_len;
      next_head_err = pkt_crc_err;
    end else if (pop && pkt_count > CNT_ONE) begin
      next_in_total = len_q[rd_ptr + PTR_ONE];
      next_head_err = err_q[rd_ptr + PTR_ONE];
    end else if (pop) begin
      next_in_total = {LEN_W{1'b0}};
      next_head_err = 1'b0;
    end else if (rx_byte_read && in_packet_byte_total != {LEN_W{1'b0}}) begin
      next_in_total = in_packet_byte_total - LEN_ONE;
    end
    // Endpoint zero tally follows loads and reads of that FIFO.
    if (ep0_empty) begin
      next_ep0_total = EP0_ZERO;
    end else begin
      next_ep0_total = ep_zero_byte_total + (ep0_load ? ep0_load_len : EP0_ZERO)
        - (ep0_byte_read ? EP0_ONE : EP0_ZERO);
    end
    // Attempts without data are counted until the limit, then restart.
    strike_hit = no_data_try && (strikes + STRIKE_ONE == `STRIKE_LIMIT);
    if (pkt_done || strike_hit) begin
      next_strikes = {`STRIKE_W{1'b0}};
    end else if (no_data_try) begin
      next_strikes = strikes + STRIKE_ONE;
    end else begin
      next_strikes = strikes;
    end
    // Sticky flags: a hardware set in the same cycle beats a software clear.
    next_stall = stall_seen ||
      (stall_received_flag && !(ctrl_wr && !wdata[`B_STALL]));
    next_noresp = !is_iso && (strike_hit ||
      (noresp_flag && !(ctrl_wr && !wdata[`B_NORESP])));
    next_nak = !is_iso && (nak_halt ||
      (nak_timeout_flag && !(ctrl_wr && !wdata[`B_CRC_NAK])));
    // A request is written by software and ends with packet, stall or strike-out.
    next_request = in_request;
    if (push || stall_seen || strike_hit) begin
      next_request = 1'b0;
    end
    if (ctrl_wr) begin
      next_request = wdata[`B_REQ] || (next_request && in_request && wdata[`B_REQ]);
    end
    // Toggle: clear has priority, then an enabled write, then the link flips it.
    next_toggle = toggle_flip ? !toggle_value : toggle_value;
    next_twe = 1'b0;
    if (ctrl_wr && wdata[`B_TOG_CLR]) begin
      next_toggle = 1'b0;
    end else if (ctrl_wr && wdata[`B_TOG_WREN]) begin
      next_toggle = wdata[`B_TOGGLE];
      next_twe = 1'b1;
    end
    // Interrupt status is write-one-to-clear, with sets winning.
    irq_set = {`IRQ_W{1'b0}};
    irq_set[`IRQ_STALL] = stall_seen;
    irq_set[`IRQ_READY] = push;
    irq_set[`IRQ_NORESP] = strike_hit && !is_iso;
    irq_set[`IRQ_NAK] = nak_halt && !is_iso;
    next_irq_status = irq_status;
    if (wr && addr == `RXEP_IRQ_STAT_ADDR) begin
      next_irq_status = irq_status & ~wdata[`IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_set;
  end

  // ----------------------------------------------------------------
  // Packet slots
  // ----------------------------------------------------------------
  // Stores the length and error of each packet that arrives while a slot is free.
  always @(posedge clk) begin
    if (push) begin
      len_q[wr_ptr] <= pkt_len;
      err_q[wr_ptr] <= pkt_crc_err;
    end
  end

  // ----------------------------------------------------------------
  // Control and status flip-flops
  // ----------------------------------------------------------------
  // Updates all control state and the registered outputs other than rdata.
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      pkt_count <= {(PTR_W+1){1'b0}};
      packet_ready_flag <= 1'b0;
      head_crc_err <= 1'b0;
      in_packet_byte_total <= {LEN_W{1'b0}};
      ep_zero_byte_total <= EP0_ZERO;
      stall_received_flag <= 1'b0;
      noresp_flag <= 1'b0;
      nak_timeout_flag <= 1'b0;
      fifo_full_flag <= 1'b0;
      toggle_write_enable <= 1'b0;
      strikes <= {`STRIKE_W{1'b0}};
      irq_status <= {`IRQ_W{1'b0}};
      irq_mask <= `IRQ_MASK_RESET;
      ep_mode <= `MODE_RESET;
      in_request <= 1'b0;
      flush_pulse <= 1'b0;
      toggle_value <= 1'b0;
      irq <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      pkt_count <= next_pkt_count;
      packet_ready_flag <= next_packet_ready;
      head_crc_err <= next_head_err;
      in_packet_byte_total <= next_in_total;
      ep_zero_byte_total <= next_ep0_total;
      stall_received_flag <= next_stall;
      noresp_flag <= next_noresp;
      nak_timeout_flag <= next_nak;
      fifo_full_flag <= (next_pkt_count == CNT_FULL);
      toggle_write_enable <= next_twe;
      strikes <= next_strikes;
      irq_status <= next_irq_status;
      if (wr && addr == `RXEP_IRQ_MASK_ADDR) begin
        irq_mask <= wdata[`IRQ_W-1:0];
      end
      if (wr && addr == `RXEP_MODE_ADDR) begin
        ep_mode <= wdata[`MODE_W-1:0];
      end
      in_request <= next_request;
      flush_pulse <= flush_hit;
      toggle_value <= next_toggle;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Returns the addressed register one cycle after the read strobe.
  always @(posedge clk) begin
    if (rst) begin
      rdata <= {`RXEP_DATA_W{1'b0}};
    end else if (rd) begin
      rdata <= {`RXEP_DATA_W{1'b0}};
      case (addr)
        `RXEP_CTRL_ADDR: begin
          rdata[`B_TOGGLE] <= toggle_value;
          rdata[`B_STALL] <= stall_received_flag;
          rdata[`B_REQ] <= in_request;
          rdata[`B_CRC_NAK] <= is_iso ? (packet_ready_flag && head_crc_err)
            : nak_timeout_flag;
          rdata[`B_NORESP] <= noresp_flag && !is_iso;
          rdata[`B_FULL] <= fifo_full_flag;
          rdata[`B_READY] <= packet_ready_flag;
        end
        `RXEP_EP0_TALLY_ADDR: begin
          rdata[EP0_W-1:0] <= ep_zero_byte_total;
        end
        `RXEP_IN_TALLY_ADDR: begin
          rdata[LEN_W-1:0] <= in_packet_byte_total;
        end
        `RXEP_IRQ_STAT_ADDR: begin
          rdata[`IRQ_W-1:0] <= irq_status;
        end
        `RXEP_IRQ_MASK_ADDR: begin
          rdata[`IRQ_W-1:0] <= irq_mask;
        end
        `RXEP_MODE_ADDR: begin
          rdata[`MODE_W-1:0] <= ep_mode;
        end
        default: begin
          rdata <= {`RXEP_DATA_W{1'b0}};
        end
      endcase
    end else begin
      rdata <= {`RXEP_DATA_W{1'b0}};
    end
  end

endmodule

`default_nettype wire
